// ---- hdl/cpu_core_map.svh ----
// Opcode fields, reset values and widths of the instruction core.
`ifndef CPU_CORE_MAP_SVH
`define CPU_CORE_MAP_SVH

`define PC_W 14
`define PAGE_W 7
`define ROM_W 10
`define RAM_AW 10
`define STACK_W 3

`define PC_RST 14'h0000
`define STACK_RST 3'h0
`define PC_ONE 14'h0001
`define BM_PAGE 7'h02

// Top three bits of the first word.
`define PFX_MISC 3'h0
`define PFX_BL 3'h1
`define PFX_BML 3'h2
`define PFX_B 3'h3
`define PFX_EXT 3'h4
`define PFX_BM 3'h5

// Bits 6 to 4 of a misc word.
`define SUB_REG 3'h0
`define SUB_ALU 3'h1
`define SUB_BIT 3'h2
`define SUB_TAM 3'h3
`define SUB_XAM 3'h4
`define SUB_XAMD 3'h5
`define SUB_ADDN 3'h6
`define SUB_LA 3'h7

// Low nibble of a register group word.
`define OP_NOP 4'h0
`define OP_TAB 4'h1
`define OP_TBA 4'h2
`define OP_TAY 4'h3
`define OP_TYA 4'h4
`define OP_TEAB 4'h5
`define OP_TABE 4'h6
`define OP_TDA 4'h7
`define OP_TAD 4'h8
`define OP_TAZ 4'h9
`define OP_AM 4'hA
`define OP_AMC 4'hB
`define OP_TAX 4'hC
`define OP_TASTACK 4'hD
`define OP_INY 4'hE
`define OP_DEY 4'hF

// Low nibble of an arithmetic and control group word.
`define OP_AND 4'h0
`define OP_OR 4'h1
`define OP_SETC 4'h2
`define OP_CLRC 4'h3
`define OP_SZC 4'h4
`define OP_CMA 4'h5
`define OP_RAR 4'h6
`define OP_RETURN 4'h7
`define OP_RETURN_SKIP 4'h8
`define OP_SKIP_EXT0 4'h9
`define OP_SEAM 4'hA
`define OP_BLA 4'hB
`define OP_BMLA 4'hC
`define OP_RETURN_INT 4'hD

// Bits 3 and 2 of a bit group word.
`define BIT_SET 2'h0
`define BIT_CLR 2'h1
`define BIT_TEST 2'h2
`define BIT_LZ 2'h3

// Bits 6 to 4 of an extended word whose bit 6 is low.
`define EXT_XAMI 3'h0
`define EXT_TMA 3'h1
`define EXT_SEA 3'h2

`endif

// ---- hdl/cpu_core_pkg.sv ----
// Types shared by the instruction core.
`default_nettype none
package cpu_core_pkg;
    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_LONG = 2'b01,
        ST_TABLE = 2'b10,
        ST_RET = 2'b11
    } core_state_t;
endpackage : cpu_core_pkg
`default_nettype wire

// ---- hdl/nibble_adder.sv ----
// Four bit adder with carry in and carry out.
`timescale 1ns/1ns
`default_nettype none
module nibble_adder #(
    parameter int W = 4
) (
    input wire logic [W-1:0] op_a,
    input wire logic [W-1:0] op_b,
    input wire logic cin,
    output logic [W-1:0] sum,
    output logic cout
);
    logic [W:0] full;

    assign full = {1'b0, op_a} + {1'b0, op_b} + {{W{1'b0}}, cin};
    assign sum = full[W-1:0];
    assign cout = full[W];
endmodule : nibble_adder
`default_nettype wire

// ---- hdl/return_stack.sv ----
// Eight level return address stack with its index.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_core_map.svh"
module return_stack #(
    parameter int DEPTH_W = `STACK_W,
    parameter int DATA_W = `PC_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic push,
    input wire logic pop,
    input wire logic [DATA_W-1:0] push_data,
    output logic [DATA_W-1:0] top_data,
    output logic [DEPTH_W-1:0] stack_index
);
    logic [DATA_W-1:0] entry_r [2**DEPTH_W];
    logic [DEPTH_W-1:0] index_r;
    logic [DEPTH_W-1:0] index_up;

    assign index_up = index_r + {{(DEPTH_W-1){1'b0}}, 1'b1};
    assign top_data = entry_r[index_r];
    assign stack_index = index_r;

    // The index moves up before the store and down after the read.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            index_r <= `STACK_RST;
        end else if (push) begin
            index_r <= index_up;
        end else if (pop) begin
            index_r <= index_r - {{(DEPTH_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            entry_r[index_up] <= push_data;
        end
    end

    a_push_store: assert property (@(posedge clk) disable iff (!nrst)
        push |=> (top_data == $past(push_data)) && (stack_index == $past(index_up)))
        else $error("pushed address not on top of stack");
endmodule : return_stack
`default_nettype wire

// ---- hdl/cpu_instruction_core.sv ----
// Instruction execution core: registers, decoder, skip logic and paged program counter.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_core_map.svh"
module cpu_instruction_core
    import cpu_core_pkg::*;
#(
    parameter logic [7:0] PAGE_COUNT = 8'h80
) (
    input wire logic clk,
    input wire logic nrst,
    output logic [`PC_W-1:0] prog_addr,
    input wire logic [`ROM_W-1:0] prog_data,
    output logic [`RAM_AW-1:0] ram_addr,
    input wire logic [3:0] ram_rdata,
    output logic [3:0] ram_wdata,
    output logic ram_we,
    input wire logic ext0_int_enable_bit,
    input wire logic ext0_request_flag,
    output logic ext0_flag_clear
);
    // --------------------------------------------------------------------
    // Architectural state
    // --------------------------------------------------------------------
    core_state_t state_r;
    logic [3:0] a_r, b_r, x_r, y_r;
    logic [7:0] e_r;
    logic [2:0] table_index_reg;
    logic [1:0] z_r;
    logic cy_r;
    logic skip_r;
    logic [`PC_W-1:0] pc_r;
    logic [`PC_W-1:0] pc_inc;
    logic [`PC_W-1:0] table_addr_r;
    logic [6:0] target_r;
    logic long_call_r, long_ind_r, long_kill_r;
    logic [`PAGE_W-1:0] pc_page_part, pc_word_part;
    logic [`RAM_AW-1:0] ram_data_pointer;

    assign pc_page_part = pc_r[`PC_W-1:`PAGE_W];
    assign pc_word_part = pc_r[`PAGE_W-1:0];
    assign pc_inc = pc_r + `PC_ONE;
    assign ram_data_pointer = {z_r, x_r, y_r};
    assign ram_addr = ram_data_pointer;
    assign prog_addr = (state_r == ST_TABLE) ? table_addr_r : pc_r;

    // --------------------------------------------------------------------
    // Decoder
    // --------------------------------------------------------------------
    logic [`ROM_W-1:0] op;
    logic [2:0] sub;
    logic [3:0] lo;
    logic exec_en;
    logic [3:0] a_nxt, b_nxt, x_nxt, y_nxt, add_b, add_sum;
    logic a_we, b_we, e_we, dr_we, x_we, y_we, z_we, cy_we, cy_nxt;
    logic ram_we_dec, skip_set, ext0_hit, add_cin, add_cout;
    logic do_branch, do_bm, do_long, long_call, long_ind, do_table, do_ret;
    logic [3:0] bit_mask;
    logic [`STACK_W-1:0] stack_index;
    logic [`PC_W-1:0] stack_top;
    logic stack_push, stack_pop;

    assign op = prog_data;
    assign sub = op[6:4];
    assign lo = op[3:0];
    assign exec_en = (state_r == ST_EXEC) && !skip_r;
    assign bit_mask = 4'h1 << op[1:0];
    assign add_b = (sub == `SUB_ADDN) ? lo : ram_rdata;
    assign add_cin = (op[9:7] == `PFX_MISC) && (sub == `SUB_REG) && (lo == `OP_AMC) && cy_r;
    assign ram_we = ram_we_dec && exec_en;

    nibble_adder #(.W(4)) u_adder (
        .op_a(a_r),
        .op_b(add_b),
        .cin(add_cin),
        .sum(add_sum),
        .cout(add_cout)
    );

    always_comb begin
        a_we = 1'b0; a_nxt = a_r; b_we = 1'b0; b_nxt = b_r;
        e_we = 1'b0; dr_we = 1'b0; z_we = 1'b0;
        x_we = 1'b0; x_nxt = x_r; y_we = 1'b0; y_nxt = y_r;
        cy_we = 1'b0; cy_nxt = cy_r;
        ram_we_dec = 1'b0; ram_wdata = ram_rdata;
        skip_set = 1'b0; ext0_hit = 1'b0;
        do_branch = 1'b0; do_bm = 1'b0; do_long = 1'b0; long_call = 1'b0;
        long_ind = 1'b0; do_table = 1'b0; do_ret = 1'b0;
        case (op[9:7])
            `PFX_MISC: begin
                case (sub)
                    `SUB_REG: begin
                        case (lo)
                            `OP_TAB: begin a_we = 1'b1; a_nxt = b_r; end
                            `OP_TBA: begin b_we = 1'b1; b_nxt = a_r; end
                            `OP_TAY: begin a_we = 1'b1; a_nxt = y_r; end
                            `OP_TYA: begin y_we = 1'b1; y_nxt = a_r; end
                            `OP_TEAB: e_we = 1'b1;
                            `OP_TABE: begin
                                a_we = 1'b1; a_nxt = e_r[3:0];
                                b_we = 1'b1; b_nxt = e_r[7:4];
                            end
                            `OP_TDA: dr_we = 1'b1;
                            `OP_TAD: begin a_we = 1'b1; a_nxt = {1'b0, table_index_reg}; end
                            `OP_TAZ: begin a_we = 1'b1; a_nxt = {2'h0, z_r}; end
                            `OP_AM: begin a_we = 1'b1; a_nxt = add_sum; end
                            `OP_AMC: begin
                                a_we = 1'b1; a_nxt = add_sum;
                                cy_we = 1'b1; cy_nxt = add_cout;
                            end
                            `OP_TAX: begin a_we = 1'b1; a_nxt = x_r; end
                            `OP_TASTACK: begin a_we = 1'b1; a_nxt = {1'b0, stack_index}; end
                            `OP_INY: begin
                                y_we = 1'b1; y_nxt = y_r + 4'h1;
                                skip_set = (y_nxt == 4'h0);
                            end
                            `OP_DEY: begin
                                y_we = 1'b1; y_nxt = y_r - 4'h1;
                                skip_set = (y_nxt == 4'hF);
                            end
                            default: ;
                        endcase
                    end
                    `SUB_ALU: begin
                        case (lo)
                            `OP_AND: begin a_we = 1'b1; a_nxt = a_r & ram_rdata; end
                            `OP_OR: begin a_we = 1'b1; a_nxt = a_r | ram_rdata; end
                            `OP_SETC: begin cy_we = 1'b1; cy_nxt = 1'b1; end
                            `OP_CLRC: begin cy_we = 1'b1; cy_nxt = 1'b0; end
                            `OP_SZC: skip_set = !cy_r;
                            `OP_CMA: begin a_we = 1'b1; a_nxt = ~a_r; end
                            `OP_RAR: begin
                                a_we = 1'b1; a_nxt = {cy_r, a_r[3:1]};
                                cy_we = 1'b1; cy_nxt = a_r[0];
                            end
                            `OP_RETURN, `OP_RETURN_INT: do_ret = 1'b1;
                            `OP_RETURN_SKIP: begin do_ret = 1'b1; skip_set = 1'b1; end
                            `OP_SKIP_EXT0: begin
                                ext0_hit = !ext0_int_enable_bit && ext0_request_flag;
                                skip_set = ext0_hit;
                            end
                            `OP_SEAM: skip_set = (a_r == ram_rdata);
                            `OP_BLA: begin do_long = 1'b1; long_ind = 1'b1; end
                            `OP_BMLA: begin
                                do_long = 1'b1; long_ind = 1'b1; long_call = 1'b1;
                            end
                            default: ;
                        endcase
                    end
                    `SUB_BIT: begin
                        case (op[3:2])
                            `BIT_SET: begin
                                ram_we_dec = 1'b1; ram_wdata = ram_rdata | bit_mask;
                            end
                            `BIT_CLR: begin
                                ram_we_dec = 1'b1; ram_wdata = ram_rdata & ~bit_mask;
                            end
                            `BIT_TEST: skip_set = ((ram_rdata & bit_mask) == 4'h0);
                            default: z_we = 1'b1;
                        endcase
                    end
                    `SUB_TAM: begin
                        a_we = 1'b1; a_nxt = ram_rdata; x_we = 1'b1; x_nxt = x_r ^ lo;
                    end
                    `SUB_XAM, `SUB_XAMD: begin
                        a_we = 1'b1; a_nxt = ram_rdata;
                        ram_we_dec = 1'b1; ram_wdata = a_r;
                        x_we = 1'b1; x_nxt = x_r ^ lo;
                        if (sub == `SUB_XAMD) begin
                            y_we = 1'b1; y_nxt = y_r - 4'h1;
                            skip_set = (y_nxt == 4'hF);
                        end
                    end
                    `SUB_ADDN: begin
                        a_we = 1'b1; a_nxt = add_sum; skip_set = !add_cout;
                    end
                    default: begin a_we = 1'b1; a_nxt = lo; end
                endcase
            end
            `PFX_BL: do_long = 1'b1;
            `PFX_BML: begin do_long = 1'b1; long_call = 1'b1; end
            `PFX_B: do_branch = 1'b1;
            `PFX_BM: do_bm = 1'b1;
            `PFX_EXT: begin
                if (op[6]) begin
                    do_table = 1'b1;
                end else begin
                    case (sub)
                        `EXT_XAMI: begin
                            a_we = 1'b1; a_nxt = ram_rdata;
                            ram_we_dec = 1'b1; ram_wdata = a_r;
                            x_we = 1'b1; x_nxt = x_r ^ lo;
                            y_we = 1'b1; y_nxt = y_r + 4'h1;
                            skip_set = (y_nxt == 4'h0);
                        end
                        `EXT_TMA: begin
                            ram_we_dec = 1'b1; ram_wdata = a_r;
                            x_we = 1'b1; x_nxt = x_r ^ lo;
                        end
                        `EXT_SEA: skip_set = (a_r == lo);
                        default: ;
                    endcase
                end
            end
            default: begin
                x_we = 1'b1; x_nxt = op[7:4]; y_we = 1'b1; y_nxt = lo;
            end
        endcase
    end

    // --------------------------------------------------------------------
    // Working registers
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_r <= 4'h0;
            b_r <= 4'h0;
        end else if (state_r == ST_TABLE) begin
            a_r <= prog_data[3:0];
            b_r <= prog_data[7:4];
        end else if (exec_en) begin
            if (a_we) a_r <= a_nxt;
            if (b_we) b_r <= b_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            e_r <= 8'h00;
            table_index_reg <= 3'h0;
            cy_r <= 1'b0;
        end else if (exec_en) begin
            if (e_we) e_r <= {b_r, a_r};
            if (dr_we) table_index_reg <= a_r[2:0];
            if (cy_we) cy_r <= cy_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            x_r <= 4'h0;
            y_r <= 4'h0;
            z_r <= 2'h0;
        end else if (exec_en) begin
            if (x_we) x_r <= x_nxt;
            if (y_we) y_r <= y_nxt;
            if (z_we) z_r <= op[1:0];
        end
    end

    // --------------------------------------------------------------------
    // Skip and external request handling
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            skip_r <= 1'b0;
        end else if (state_r == ST_EXEC) begin
            skip_r <= skip_r ? 1'b0 : skip_set;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext0_flag_clear <= 1'b0;
        end else begin
            ext0_flag_clear <= exec_en && ext0_hit;
        end
    end

    // --------------------------------------------------------------------
    // Sequencing and program counter
    // --------------------------------------------------------------------
    logic [`PAGE_W-1:0] long_page;
    logic long_ok;

    assign long_page = op[`PAGE_W-1:0];
    assign long_ok = !long_kill_r && ({1'b0, long_page} < PAGE_COUNT);
    assign stack_push = (exec_en && do_bm) || (state_r == ST_LONG && long_ok && long_call_r);
    assign stack_pop = exec_en && do_ret;

    return_stack #(.DEPTH_W(`STACK_W), .DATA_W(`PC_W)) u_stack (
        .clk(clk),
        .nrst(nrst),
        .push(stack_push),
        .pop(stack_pop),
        .push_data(pc_inc),
        .top_data(stack_top),
        .stack_index(stack_index)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_EXEC;
            pc_r <= `PC_RST;
            table_addr_r <= `PC_RST;
            target_r <= 7'h00;
            long_call_r <= 1'b0;
            long_ind_r <= 1'b0;
            long_kill_r <= 1'b0;
        end else begin
            case (state_r)
                ST_EXEC: begin
                    pc_r <= pc_inc;
                    if (do_long) begin
                        state_r <= ST_LONG;
                        target_r <= op[6:0];
                        long_call_r <= long_call;
                        long_ind_r <= long_ind;
                        long_kill_r <= skip_r;
                    end else if (!skip_r) begin
                        if (do_branch) begin
                            pc_r <= {pc_page_part, op[6:0]};
                        end else if (do_bm) begin
                            pc_r <= {`BM_PAGE, op[6:0]};
                        end else if (do_table) begin
                            state_r <= ST_TABLE;
                            table_addr_r <= {op[5:0] == 6'h00 ? pc_page_part : {1'b0, op[5:0]},
                                table_index_reg, a_r};
                        end else if (do_ret) begin
                            state_r <= ST_RET;
                            pc_r <= stack_top;
                        end
                    end
                end
                ST_LONG: begin
                    state_r <= ST_EXEC;
                    if (long_ok) begin
                        pc_r <= {long_page, long_ind_r ? {table_index_reg, a_r} : target_r};
                    end else begin
                        pc_r <= pc_inc;
                    end
                end
                ST_TABLE: state_r <= ST_RET;
                default: state_r <= ST_EXEC;
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic ret_op;
    assign ret_op = (op[9:7] == `PFX_MISC) && (sub == `SUB_ALU) && (lo >= `OP_RETURN)
        && (lo <= `OP_RETURN_SKIP);

    sequence ret_tail;
        (state_r == ST_RET) ##1 (state_r == ST_EXEC);
    endsequence

    a_skip_no_write: assert property ((state_r == ST_EXEC) && skip_r |-> !ram_we)
        else $error("skipped instruction wrote memory");
    a_skip_pc_step: assert property ((state_r == ST_EXEC) && skip_r |=>
        pc_r == $past(pc_r) + `PC_ONE)
        else $error("skip did not step one word");
    a_skip_ret_short: assert property ((state_r == ST_EXEC) && skip_r && ret_op |=>
        state_r == ST_EXEC)
        else $error("skipped return took extra cycle");
    a_ret_cycles: assert property (exec_en && ret_op |=> ret_tail)
        else $error("return did not take two cycles");
    a_short_branch: assert property (exec_en && do_branch |=>
        pc_r[13:7] == $past(pc_r[13:7]) && pc_r[6:0] == $past(op[6:0]))
        else $error("short branch left page");
    a_bit_set: assert property (exec_en && op[9:4] == 6'h02 && op[3:2] == `BIT_SET |->
        ram_we && (ram_wdata & bit_mask) != 4'h0)
        else $error("bit set did not write one");
    a_xch_swap: assert property (exec_en && sub == `SUB_XAM && op[9:7] == `PFX_MISC |->
        ram_we && ram_wdata == a_r ##1 a_r == $past(ram_rdata))
        else $error("exchange lost a value");
    a_ext0_skip: assert property (exec_en && ext0_hit |=> skip_r && ext0_flag_clear)
        else $error("external request test did not skip and clear");
    a_call_push: assert property (exec_en && do_bm |=>
        stack_index == $past(stack_index) + 3'h1)
        else $error("call did not raise stack index");
    a_skip_once: assert property ((state_r == ST_EXEC) && skip_r |=> !skip_r)
        else $error("skip covered more than one slot");
    a_page_limit: assert property ((state_r == ST_LONG) && !long_kill_r &&
        {1'b0, long_page} >= PAGE_COUNT |=> pc_r == $past(pc_r) + `PC_ONE)
        else $error("long branch to page beyond memory");
endmodule : cpu_instruction_core
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the instruction core with program and data memory models.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_core_map.svh"
module tb_top import cpu_core_pkg::*;;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [`PC_W-1:0] prog_addr;
    logic [`ROM_W-1:0] prog_data;
    logic [`RAM_AW-1:0] ram_addr;
    logic [3:0] ram_rdata;
    logic [3:0] ram_wdata;
    logic ram_we;
    logic ext0_int_enable_bit = 1'b1;
    logic ext0_request_flag = 1'b0;
    logic ext0_flag_clear;
    logic [`ROM_W-1:0] rom [0:16383];
    logic [3:0] ram [0:1023];
    int error_cnt = 0;
    int check_count = 0;
    // ----------------------------------------
    // Memories: combinational reads, RAM write at the clock edge.
    // ----------------------------------------
    assign prog_data = rom[prog_addr];
    assign ram_rdata = ram[ram_addr];
    always @(posedge clk) begin
        if (ram_we === 1'b1) begin
            ram[ram_addr] <= ram_wdata;
        end
    end
    cpu_instruction_core #(.PAGE_COUNT(8'h40)) i_dut (
        .clk(clk), .nrst(nrst), .prog_addr(prog_addr), .prog_data(prog_data),
        .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_wdata(ram_wdata), .ram_we(ram_we),
        .ext0_int_enable_bit(ext0_int_enable_bit), .ext0_request_flag(ext0_request_flag),
        .ext0_flag_clear(ext0_flag_clear)
    );
    initial begin
        forever #25 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks.
    // ----------------------------------------
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task close_out;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task run(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : run
    // Holds reset for six cycles and clears both memories to no-op and zero.
    task boot(input logic en, input logic req);
        @(posedge clk);
        nrst <= 1'b0;
        ext0_int_enable_bit <= en;
        ext0_request_flag <= req;
        #1;
        for (int i = 0; i < 16384; i++) rom[i] = 10'h000;
        for (int i = 0; i < 1024; i++) ram[i] = 4'h0;
        run(6);
        chk("reset address", 16'(prog_addr), 16'h0000);
    endtask : boot
    task go(input int n);
        @(posedge clk);
        nrst <= 1'b1;
        run(n);
    endtask : go
    // ----------------------------------------
    // Scenarios.
    // ----------------------------------------
    task t_skip;
        boot(1'b1, 1'b0);
        rom[0] = 10'h300; rom[1] = 10'h071; rom[2] = 10'h061; rom[3] = 10'h077;
        rom[4] = 10'h061; rom[5] = 10'h017; rom[6] = 10'h210;
        go(6);
        chk("skip address", 16'(prog_addr), 16'h0006);
        run(1);
        chk("skip result", 16'(ram[0]), 16'h0003);
        $display("skip test done");
    endtask : t_skip
    task t_xchg;
        boot(1'b1, 1'b0);
        ram[10'h234] = 4'h9;
        rom[0] = 10'h02E; rom[1] = 10'h334; rom[2] = 10'h075; rom[3] = 10'h041; rom[4] = 10'h210;
        go(3);
        chk("data pointer", 16'(ram_addr), 16'h0234);
        run(2);
        chk("exchanged word", 16'(ram[10'h234]), 16'h0005);
        chk("moved word", 16'(ram[10'h224]), 16'h0009);
        $display("exchange test done");
    endtask : t_xchg
    task t_bits;
        for (int j = 0; j < 4; j++) begin
            boot(1'b1, 1'b0);
            ram[1] = 4'hF;
            rom[0] = 10'h300; rom[1] = 10'(10'h020 + j); rom[2] = 10'h301; rom[3] = 10'(10'h024 + j);
            go(4);
            chk("set bit", 16'(ram[0]), 16'(1 << j));
            chk("clear bit", 16'(ram[1]), 16'(4'hF ^ (1 << j)));
        end
        $display("bit test done");
    endtask : t_bits
    task t_branch;
        boot(1'b1, 1'b0);
        rom[0] = 10'h085; rom[1] = 10'h003; rom[14'h0185] = 10'h190;
        go(2);
        chk("long branch", 16'(prog_addr), 16'h0185);
        run(1);
        chk("short branch", 16'(prog_addr), 16'h0190);
        boot(1'b1, 1'b0);
        rom[0] = 10'h085; rom[1] = 10'h050;
        go(2);
        chk("page limit", 16'(prog_addr), 16'h0002);
        $display("branch test done");
    endtask : t_branch
    task t_ext0;
        for (int k = 0; k < 2; k++) begin
            boot(k[0], 1'b1);
            ram[0] = 4'hF;
            rom[0] = 10'h300; rom[1] = 10'h019; rom[2] = 10'h076; rom[3] = 10'h210;
            go(2);
            chk("flag clear", 16'(ext0_flag_clear), 16'(k == 0));
            run(1);
            chk("flag clear end", 16'(ext0_flag_clear), 16'h0000);
            run(1);
            chk("ext0 result", 16'(ram[0]), (k == 0) ? 16'h0000 : 16'h0006);
        end
        $display("ext0 test done");
    endtask : t_ext0
    // Calls into page two, reads a table word, returns and moves it through the extension.
    task t_call;
        boot(1'b1, 1'b0);
        rom[0] = 10'h290; rom[1] = 10'h005; rom[2] = 10'h070; rom[3] = 10'h006;
        rom[4] = 10'h210; rom[5] = 10'h001; rom[6] = 10'h301; rom[7] = 10'h210;
        rom[14'h0110] = 10'h075; rom[14'h0111] = 10'h243; rom[14'h0112] = 10'h017;
        rom[14'h0185] = 10'h0A7;
        go(1);
        chk("call target", 16'(prog_addr), 16'h0110);
        run(2);
        chk("table address", 16'(prog_addr), 16'h0185);
        run(4);
        chk("return address", 16'(prog_addr), 16'h0001);
        run(7);
        chk("table low nibble", 16'(ram[0]), 16'h0007);
        chk("table high nibble", 16'(ram[1]), 16'h000A);
        $display("call test done");
    endtask : t_call
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    initial begin
        t_skip();
        t_xchg();
        t_bits();
        t_branch();
        t_ext0();
        t_call();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
